// [shared/ecmc_cfg.svh]
// Register map, float constants, reset values and timing for mux control
`ifndef ECMC_CFG_SVH
`define ECMC_CFG_SVH

// Register start addresses (protocol word addresses, 32-bit values)
`define ECMC_ADDR_STREAM_SETTLE 16'h0fa8
`define ECMC_ADDR_SPAN_ARRAY 16'h9ca0
`define ECMC_ADDR_SETTLE_ARRAY 16'ha470
`define ECMC_ADDR_GLOBAL_SPAN 16'hab7c
`define ECMC_ADDR_GLOBAL_SETTLE 16'hab80
// Channel that sits at each array start address
`define ECMC_ARRAY_FIRST_CH 7'h30
// Words taken by one float entry in the address space
`define ECMC_WORDS_PER_ENTRY 16'h0002

// Channel numbering
`define ECMC_EXT_FIRST_CH 7'h10
`define ECMC_EXT_NEG_STEP 7'h08
`define ECMC_BUILTIN_COUNT 14

// Float32 constants
`define ECMC_FLOAT_DISAGREE 32'hc61c3c00
`define ECMC_FLOAT_ONE 32'h3f800000
`define ECMC_SETTLE_MAX 32'h47435000

// Reset values
`define ECMC_STREAM_SETTLE_RST 32'h00000000
`define ECMC_SPAN_RST 32'h41200000
`define ECMC_SETTLE_RST 32'h00000000

// Timing
`define ECMC_CLK_MHZ 125
`define ECMC_AUTO_SETTLE_US 10
`define ECMC_AUTO_SETTLE_CYC (`ECMC_AUTO_SETTLE_US * `ECMC_CLK_MHZ)

`endif

// [shared/ecmc_pkg.sv]
// Types shared by the extended channel mux control
package ecmc_pkg;
   // Measurement sequencer states
   typedef enum logic [1:0]
   {
      ECMC_IDLE = 2'b00,
      ECMC_FETCH = 2'b01,
      ECMC_SETTLE = 2'b10,
      ECMC_START = 2'b11
   } ecmc_state_t;
   // Channel number and built-in input index
   typedef logic [6:0] ecmc_chan_t;
   typedef logic [3:0] ecmc_builtin_t;
endpackage

// [src/ecmc_store.sv]
// Small per-channel store with one write port and a registered read port
`timescale 1ns/10ps
module ecmc_store #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   // Clock
   input wire logic clk_sys_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   // Read port
   input wire logic rd_en_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   // Storage array, no reset; contents loaded by the init sweep
   logic [WIDTH-1:0] mem_r [DEPTH];

   // Write and registered read
   always_ff @(posedge clk_sys_i)
   begin
      if (wr_en_i)
      begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
      if (rd_en_i)
      begin
         rd_data_o <= mem_r[rd_addr_i];
      end
   end
endmodule

// [src/ecmc_top.sv]
// Extended analog channel mux control: registers, mapping, settling
`timescale 1ns/10ps
`include "ecmc_cfg.svh"

module ecmc_top #(
   parameter int CHANNELS = 128,
   parameter int SETTLE_CNT_W = 24
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic reg_busy_o,
   // Built-in inputs that carry an external mux
   input wire logic [`ECMC_BUILTIN_COUNT-1:0] expand_mask_i,
   // Measurement request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire ecmc_pkg::ecmc_chan_t req_chan_i,
   input wire logic req_diff_i,
   input wire logic req_stream_i,
   input wire logic req_first_i,
   output logic done_o,
   output logic err_o,
   // Converter side
   output logic conv_start_o,
   output ecmc_pkg::ecmc_builtin_t conv_pos_o,
   output ecmc_pkg::ecmc_builtin_t conv_neg_o,
   output logic conv_diff_o,
   output logic [31:0] conv_span_o,
   // External mux address lines
   output logic mux_select_line0_o,
   output logic mux_select_line1_o,
   output logic mux_select_line2_o
);
   import ecmc_pkg::*;

   // Float32 to whole microseconds, truncated, saturating at 16 bits
   function automatic logic [15:0] ecmc_f2us(input logic [31:0] f);
      logic [23:0] mant;
      logic [7:0] sh;
      logic [23:0] val;
      mant = {1'b1, f[22:0]};
      sh = 8'h96 - f[30:23];
      val = mant >> sh;
      if (f[31] || f[30:23] < 8'h7f)
      begin
         ecmc_f2us = 16'h0000;
      end
      else if (f[30:23] > 8'h8e)
      begin
         ecmc_f2us = 16'hffff;
      end
      else
      begin
         ecmc_f2us = val[15:0];
      end
   endfunction

   // Clamp a settle value to 0 .. the accepted maximum
   function automatic logic [31:0] ecmc_clamp(input logic [31:0] f);
      if (f[31])
      begin
         ecmc_clamp = 32'h00000000;
      end
      else if (f > `ECMC_SETTLE_MAX)
      begin
         ecmc_clamp = `ECMC_SETTLE_MAX;
      end
      else
      begin
         ecmc_clamp = f;
      end
   endfunction

   // Register state
   logic [31:0] stream_settle_r, stream_settle_nxt; // Stream settle float
   logic [31:0] span_all_r, span_all_nxt; // Last global span
   logic [31:0] settle_all_r, settle_all_nxt; // Last global settle
   logic span_same_r, span_same_nxt; // All spans agree
   logic settle_same_r, settle_same_nxt; // All settles agree
   logic sweep_span_r, sweep_span_nxt; // Span sweep running
   logic sweep_settle_r, sweep_settle_nxt; // Settle sweep running
   logic [6:0] sweep_idx_r, sweep_idx_nxt; // Sweep entry
   logic rd_pend_r, rd_pend_nxt; // Read in flight
   logic [2:0] rd_src_r, rd_src_nxt; // Read source select
   logic [31:0] rdata_r, rdata_nxt; // Read data
   logic rvalid_r, rvalid_nxt; // Read data valid
   // Decode
   logic [15:0] span_off, settle_off; // Offsets from channel-0 bases
   logic span_hit, settle_hit; // Array address hits
   logic [6:0] bus_ch; // Channel addressed on the bus
   logic busy; // Sweep in progress
   // Store ports
   logic span_we, settle_we;
   logic [6:0] span_wa, settle_wa, store_ra;
   logic [31:0] span_wd, settle_wd, span_rd, settle_rd;
   logic store_re, accept;

   // Array offsets measured from where channel 0 would sit
   assign span_off = reg_addr_i - (`ECMC_ADDR_SPAN_ARRAY -
      16'({`ECMC_ARRAY_FIRST_CH, 1'b0}));
   assign settle_off = reg_addr_i - (`ECMC_ADDR_SETTLE_ARRAY -
      16'({`ECMC_ARRAY_FIRST_CH, 1'b0}));
   assign span_hit = !span_off[0] && span_off < 16'(CHANNELS * 2);
   assign settle_hit = !settle_off[0] && settle_off < 16'(CHANNELS * 2);
   assign bus_ch = span_hit ? span_off[7:1] : settle_off[7:1];
   assign busy = sweep_span_r || sweep_settle_r;
   assign reg_busy_o = busy;
   assign reg_rdata_o = rdata_r;
   assign reg_rvalid_o = rvalid_r;

   // Store write and read steering
   always_comb
   begin
      span_we = sweep_span_r || (!busy && reg_wr_i && span_hit);
      settle_we = sweep_settle_r || (!busy && reg_wr_i && settle_hit);
      span_wa = sweep_span_r ? sweep_idx_r : bus_ch;
      settle_wa = sweep_settle_r ? sweep_idx_r : bus_ch;
      span_wd = sweep_span_r ? span_all_r : reg_wdata_i;
      settle_wd = sweep_settle_r ? settle_all_r : ecmc_clamp(reg_wdata_i);
      store_re = reg_rd_i || accept;
      store_ra = reg_rd_i ? bus_ch : req_chan_i;
   end

   // Per-channel span and settle stores
   ecmc_store #(.WIDTH(32), .DEPTH(CHANNELS), .AW(7)) u_span (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(span_we),
      .wr_addr_i(span_wa),
      .wr_data_i(span_wd),
      .rd_en_i(store_re),
      .rd_addr_i(store_ra),
      .rd_data_o(span_rd)
   );
   ecmc_store #(.WIDTH(32), .DEPTH(CHANNELS), .AW(7)) u_settle (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(settle_we),
      .wr_addr_i(settle_wa),
      .wr_data_i(settle_wd),
      .rd_en_i(store_re),
      .rd_addr_i(store_ra),
      .rd_data_o(settle_rd)
   );

   // Register writes, global sweeps and read return
   always_comb
   begin
      stream_settle_nxt = stream_settle_r;
      span_all_nxt = span_all_r;
      settle_all_nxt = settle_all_r;
      span_same_nxt = span_same_r;
      settle_same_nxt = settle_same_r;
      sweep_span_nxt = sweep_span_r;
      sweep_settle_nxt = sweep_settle_r;
      sweep_idx_nxt = sweep_idx_r;
      rd_pend_nxt = reg_rd_i;
      rd_src_nxt = 3'h0;
      rdata_nxt = rdata_r;
      rvalid_nxt = rd_pend_r;
      // Sweep walks every entry, one per cycle
      if (busy)
      begin
         sweep_idx_nxt = sweep_idx_r + 7'h01;
         if (sweep_idx_r == 7'(CHANNELS - 1))
         begin
            sweep_span_nxt = 1'b0;
            sweep_settle_nxt = 1'b0;
            sweep_idx_nxt = 7'h00;
         end
      end
      // Writes are dropped while a sweep runs
      else if (reg_wr_i)
      begin
         if (reg_addr_i == `ECMC_ADDR_STREAM_SETTLE)
         begin
            stream_settle_nxt = reg_wdata_i;
         end
         else if (reg_addr_i == `ECMC_ADDR_GLOBAL_SPAN)
         begin
            span_all_nxt = reg_wdata_i;
            span_same_nxt = 1'b1;
            sweep_span_nxt = 1'b1;
         end
         else if (reg_addr_i == `ECMC_ADDR_GLOBAL_SETTLE)
         begin
            settle_all_nxt = ecmc_clamp(reg_wdata_i);
            settle_same_nxt = 1'b1;
            sweep_settle_nxt = 1'b1;
         end
         else if (span_hit && reg_wdata_i != span_all_r)
         begin
            span_same_nxt = 1'b0;
         end
         else if (settle_hit && ecmc_clamp(reg_wdata_i) != settle_all_r)
         begin
            settle_same_nxt = 1'b0;
         end
      end
      // Remember where a read comes from
      if (reg_rd_i)
      begin
         if (reg_addr_i == `ECMC_ADDR_STREAM_SETTLE)
            rd_src_nxt = 3'h1;
         else if (reg_addr_i == `ECMC_ADDR_GLOBAL_SPAN)
            rd_src_nxt = 3'h2;
         else if (reg_addr_i == `ECMC_ADDR_GLOBAL_SETTLE)
            rd_src_nxt = 3'h3;
         else if (span_hit)
            rd_src_nxt = 3'h4;
         else if (settle_hit)
            rd_src_nxt = 3'h5;
         else
            rd_src_nxt = 3'h0;
      end
      // Read data one cycle after the store answers
      if (rd_pend_r)
      begin
         case (rd_src_r)
            3'h1: rdata_nxt = stream_settle_r;
            3'h2: rdata_nxt = span_same_r ? span_all_r :
               `ECMC_FLOAT_DISAGREE;
            3'h3: rdata_nxt = settle_same_r ? settle_all_r :
               `ECMC_FLOAT_DISAGREE;
            3'h4: rdata_nxt = span_rd;
            3'h5: rdata_nxt = settle_rd;
            default: rdata_nxt = 32'h00000000; // Unmapped reads zero
         endcase
      end
   end

   // Register state flops; reset starts the loading sweep of both stores
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stream_settle_r <= `ECMC_STREAM_SETTLE_RST;
         span_all_r <= `ECMC_SPAN_RST;
         settle_all_r <= `ECMC_SETTLE_RST;
         span_same_r <= 1'b1;
         settle_same_r <= 1'b1;
         sweep_span_r <= 1'b1;
         sweep_settle_r <= 1'b1;
         sweep_idx_r <= 7'h00;
         rd_pend_r <= 1'b0;
         rd_src_r <= 3'h0;
         rdata_r <= 32'h00000000;
         rvalid_r <= 1'b0;
      end
      else
      begin
         stream_settle_r <= stream_settle_nxt;
         span_all_r <= span_all_nxt;
         settle_all_r <= settle_all_nxt;
         span_same_r <= span_same_nxt;
         settle_same_r <= settle_same_nxt;
         sweep_span_r <= sweep_span_nxt;
         sweep_settle_r <= sweep_settle_nxt;
         sweep_idx_r <= sweep_idx_nxt;
         rd_pend_r <= rd_pend_nxt;
         rd_src_r <= rd_src_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // Sequencer state
   ecmc_state_t state_r, state_nxt;
   logic [2:0] sel_r, sel_nxt; // Shared mux select
   ecmc_builtin_t pos_r, pos_nxt, neg_r, neg_nxt;
   logic diff_r, diff_nxt;
   logic [31:0] span_r, span_nxt;
   logic stream_r, stream_nxt; // Request is a stream sample
   logic first_r, first_nxt; // First channel of the scan
   logic [SETTLE_CNT_W-1:0] cnt_r, cnt_nxt; // Settle countdown
   logic start_r, start_nxt, done_r, done_nxt, err_r, err_nxt;
   // Request decode
   logic ext; // Extended channel requested
   logic [6:0] ext_off; // Channel minus first extended
   ecmc_builtin_t req_bi; // Built-in input carrying the channel
   logic req_bad; // Request cannot be honoured
   logic [15:0] settle_us; // Settle time in whole us

   assign accept = req_valid_i && req_ready_o;
   assign req_ready_o = state_r == ECMC_IDLE && !busy && !reg_rd_i;
   assign ext = req_chan_i >= `ECMC_EXT_FIRST_CH;
   assign ext_off = req_chan_i - `ECMC_EXT_FIRST_CH;
   assign req_bi = ext ? ecmc_builtin_t'(ext_off[6:3]) :
      ecmc_builtin_t'(req_chan_i[3:0]);

   // Legality of the requested channel and pairing
   always_comb
   begin
      req_bad = 1'b0;
      if (!ext)
      begin
         // Unused numbers and inputs given over to a mux
         req_bad = req_chan_i >= 7'(`ECMC_BUILTIN_COUNT) ||
            expand_mask_i[req_chan_i[3:0]];
         if (req_diff_i && req_chan_i[0])
            req_bad = 1'b1;
      end
      else if (req_diff_i && ext_off[3])
      begin
         req_bad = 1'b1;
      end
   end

   // Settle time picked for this sample
   always_comb
   begin
      settle_us = ecmc_f2us(settle_rd);
      if (stream_r)
      begin
         settle_us = ecmc_f2us(stream_settle_r);
      end
   end

   // Sequencer next state
   always_comb
   begin
      state_nxt = state_r;
      sel_nxt = sel_r;
      pos_nxt = pos_r;
      neg_nxt = neg_r;
      diff_nxt = diff_r;
      span_nxt = span_r;
      stream_nxt = stream_r;
      first_nxt = first_r;
      cnt_nxt = cnt_r;
      start_nxt = 1'b0;
      done_nxt = 1'b0;
      err_nxt = 1'b0;
      case (state_r)
         ECMC_IDLE:
         begin
            if (accept && req_bad)
            begin
               done_nxt = 1'b1;
               err_nxt = 1'b1;
            end
            else if (accept)
            begin
               // Lines move now, ahead of any settling
               if (ext)
                  sel_nxt = ext_off[2:0];
               pos_nxt = req_bi;
               neg_nxt = ext ? req_bi + 4'h1 :
                  ecmc_builtin_t'(req_chan_i[3:0] + 4'h1);
               diff_nxt = req_diff_i;
               stream_nxt = req_stream_i;
               first_nxt = req_first_i;
               state_nxt = ECMC_FETCH;
            end
         end
         ECMC_FETCH:
         begin
            span_nxt = span_rd;
            if (stream_r && first_r)
               cnt_nxt = '0;
            else if (stream_r && stream_settle_r[31])
               cnt_nxt = SETTLE_CNT_W'(`ECMC_AUTO_SETTLE_CYC);
            else if (stream_r && stream_settle_r < `ECMC_FLOAT_ONE)
               cnt_nxt = SETTLE_CNT_W'(`ECMC_AUTO_SETTLE_CYC);
            else
               cnt_nxt = SETTLE_CNT_W'(settle_us * `ECMC_CLK_MHZ);
            state_nxt = ECMC_SETTLE;
         end
         ECMC_SETTLE:
         begin
            // Lines hold steady through the whole wait
            if (cnt_r == '0)
               state_nxt = ECMC_START;
            else
               cnt_nxt = cnt_r - 1'b1;
         end
         ECMC_START:
         begin
            start_nxt = 1'b1;
            done_nxt = 1'b1;
            state_nxt = ECMC_IDLE;
         end
         default: state_nxt = ECMC_IDLE;
      endcase
   end

   // Sequencer flops
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= ECMC_IDLE;
         sel_r <= 3'h0;
         pos_r <= 4'h0;
         neg_r <= 4'h0;
         diff_r <= 1'b0;
         span_r <= 32'h00000000;
         stream_r <= 1'b0;
         first_r <= 1'b0;
         cnt_r <= '0;
         start_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         sel_r <= sel_nxt;
         pos_r <= pos_nxt;
         neg_r <= neg_nxt;
         diff_r <= diff_nxt;
         span_r <= span_nxt;
         stream_r <= stream_nxt;
         first_r <= first_nxt;
         cnt_r <= cnt_nxt;
         start_r <= start_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
      end
   end

   // One select drives all external muxes in common
   assign mux_select_line0_o = sel_r[0];
   assign mux_select_line1_o = sel_r[1];
   assign mux_select_line2_o = sel_r[2];
   assign conv_start_o = start_r;
   assign conv_pos_o = pos_r;
   assign conv_neg_o = neg_r;
   assign conv_diff_o = diff_r;
   assign conv_span_o = span_r;
   assign done_o = done_r;
   assign err_o = err_r;
endmodule

// [testbench/ecmc_mux_model.sv]
// Behavioural external 8:1 multiplexers behind the select lines
`timescale 1ns/10ps
module ecmc_mux_model
(
   // Select lines and the built-in input being sampled
   input wire logic sel0_i,
   input wire logic sel1_i,
   input wire logic sel2_i,
   input wire ecmc_pkg::ecmc_builtin_t builtin_i,
   // Extended channel whose signal reaches that input
   output ecmc_pkg::ecmc_chan_t route_ch_o
);
   import ecmc_pkg::*;
   // Each mux passes its selected input; bank n starts at n*8+16
   assign route_ch_o = {builtin_i, 3'h0} + 7'h10 +
      {4'h0, sel2_i, sel1_i, sel0_i};
endmodule

// [testbench/ecmc_top_chk.sv]
// Concurrent checks on the ports of the mux control
`timescale 1ns/10ps
module ecmc_top_chk
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Register and request side
   input wire logic reg_rd_i,
   input wire logic reg_rvalid_o,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire ecmc_pkg::ecmc_chan_t req_chan_i,
   input wire logic req_diff_i,
   input wire logic req_stream_i,
   input wire logic req_first_i,
   // Results, converter side and select lines
   input wire logic done_o,
   input wire logic err_o,
   input wire logic conv_start_o,
   input wire ecmc_pkg::ecmc_builtin_t conv_pos_o,
   input wire ecmc_pkg::ecmc_builtin_t conv_neg_o,
   input wire logic conv_diff_o,
   input wire logic mux_select_line0_o,
   input wire logic mux_select_line1_o,
   input wire logic mux_select_line2_o
);
   import ecmc_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   logic acc; // Request taken this edge
   logic ext; // Extended channel requested
   logic [6:0] off; // Offset from the first extended channel
   logic [2:0] sel; // Select value on the lines
   assign acc = req_valid_i && req_ready_o;
   assign ext = req_chan_i >= 7'h10;
   assign off = req_chan_i - 7'h10;
   assign sel = {mux_select_line2_o, mux_select_line1_o, mux_select_line0_o};
   // Accepted single-ended extended read
   sequence s_single;
      acc && ext && !req_diff_i;
   endsequence
   // Accepted extended pair from a lower block
   sequence s_pair;
      acc && ext && !off[3] && req_diff_i;
   endsequence
   // Lines and input set for the channel just taken
   property p_map;
      ecmc_chan_t c;
      (s_single, c = req_chan_i) |=> sel == c[2:0] &&
         conv_pos_o == 4'((c - 7'h10) >> 3);
   endproperty
   AST_SEL_MAP: assert property (p_map)
      else $error("select lines or input wrong for channel");
   AST_PAIR_NEG: assert property (s_pair |=> conv_diff_o && !err_o &&
      conv_neg_o == conv_pos_o + 4'h1)
      else $error("extended pair negative input wrong");
   AST_UPPER_ERR: assert property (acc && ext && off[3] && req_diff_i
      |=> done_o && err_o)
      else $error("upper block positive not refused");
   AST_ODD_ERR: assert property (acc && !ext && req_chan_i[0] &&
      req_diff_i |=> done_o && err_o)
      else $error("odd built-in positive not refused");
   AST_LEAD: assert property (s_single |=> (!conv_start_o) [*2])
      else $error("conversion started before settling");
   AST_HOLD: assert property (!$past(acc) |-> $stable(sel))
      else $error("select lines moved without a request");
   AST_FIRST: assert property (acc && req_stream_i && req_first_i &&
      ext && !req_diff_i |-> ##4 conv_start_o)
      else $error("first scan channel was delayed");
   AST_START_DONE: assert property (conv_start_o |-> done_o && !err_o)
      else $error("start without a clean finish");
   AST_RVALID: assert property ($past(reg_rd_i, 2) == reg_rvalid_o)
      else $error("read answer not two cycles after read");
endmodule
bind ecmc_top ecmc_top_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
   .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
   .req_chan_i(req_chan_i), .req_diff_i(req_diff_i),
   .req_stream_i(req_stream_i), .req_first_i(req_first_i),
   .done_o(done_o), .err_o(err_o), .conv_start_o(conv_start_o),
   .conv_pos_o(conv_pos_o), .conv_neg_o(conv_neg_o),
   .conv_diff_o(conv_diff_o), .mux_select_line0_o(mux_select_line0_o),
   .mux_select_line1_o(mux_select_line1_o),
   .mux_select_line2_o(mux_select_line2_o));

// [testbench/testbench.sv]
// Self-checking bench for the extended channel mux control
`timescale 1ns/10ps
`include "ecmc_cfg.svh"
module testbench;
   import ecmc_pkg::*;
   // Expected outcome of one measurement request
   typedef struct {logic err; logic dif; logic [3:0] pos; logic [3:0] neg;
      logic [6:0] ch; logic [31:0] span; int due;} ecmc_note_t;
   logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_busy_o;
   logic [15:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, conv_span_o;
   logic [13:0] expand_mask_i; // Built-in inputs carrying a mux
   logic req_valid_i, req_ready_o, req_diff_i, req_stream_i, req_first_i;
   logic done_o, err_o, conv_start_o, conv_diff_o, sel0, sel1, sel2;
   ecmc_chan_t req_chan_i, route_ch;
   ecmc_builtin_t conv_pos_o, conv_neg_o;
   ecmc_note_t nq[$]; // Notes of pending requests
   ecmc_note_t m; // Note being compared
   logic [31:0] rq[$]; // Expected read data
   int n_mismatch = 0, num_checks = 0, cyc = 0, k;
   logic [15:0] lfsr = 16'h9409; // Random source seed
   // Clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // Edge counter used for answer timing
   always @(posedge clk_sys_i) cyc <= cyc + 1;
   ecmc_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .reg_busy_o(reg_busy_o),
      .expand_mask_i(expand_mask_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_chan_i(req_chan_i),
      .req_diff_i(req_diff_i), .req_stream_i(req_stream_i),
      .req_first_i(req_first_i), .done_o(done_o), .err_o(err_o),
      .conv_start_o(conv_start_o), .conv_pos_o(conv_pos_o),
      .conv_neg_o(conv_neg_o), .conv_diff_o(conv_diff_o),
      .conv_span_o(conv_span_o), .mux_select_line0_o(sel0),
      .mux_select_line1_o(sel1), .mux_select_line2_o(sel2));
   // External muxes on the select lines
   ecmc_mux_model u_mux (.sel0_i(sel0), .sel1_i(sel1), .sel2_i(sel2),
      .builtin_i(conv_pos_o), .route_ch_o(route_ch));
   // Compare one value and count it
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Print counts and verdict, then end the run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Next random value
   function automatic logic [15:0] step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Bounded wait for the end of a sweep
   task automatic wait_free();
      for (int i = 0; i < 400 && reg_busy_o !== 1'b0; i++)
      begin
         @(posedge clk_sys_i);
         #1;
      end
      if (reg_busy_o !== 1'b0)
      begin
         n_mismatch++;
         stop_test();
      end
   endtask
   // Register write, then let any sweep finish
   task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(posedge clk_sys_i);
      #1 reg_wr_i = 1'b0;
      @(posedge clk_sys_i);
      #1 wait_free();
   endtask
   // Register read; the expected data goes on the queue
   task automatic reg_read(input logic [15:0] a, input logic [31:0] e);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(posedge clk_sys_i);
      rq.push_back(e);
      #1 reg_rd_i = 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask
   // One measurement request with its expected outcome
   task automatic req(input logic [6:0] c, input logic d, s, f,
      input int n_set, input logic [31:0] sp);
      ecmc_note_t n;
      logic [6:0] o;
      int i;
      @(posedge clk_sys_i);
      #1 o = c - 7'h10;
      n.ch = c;
      n.dif = d;
      n.span = sp;
      n.pos = (c >= 7'h10) ? o[6:3] : c[3:0];
      n.neg = n.pos + 4'h1;
      if (c >= 7'h10)
         n.err = d & o[3];
      else
         n.err = c > 7'h0d || expand_mask_i[c[3:0]] || (d && c[0]);
      req_chan_i = c;
      req_diff_i = d;
      req_stream_i = s;
      req_first_i = f;
      req_valid_i = 1'b1;
      for (i = 0; i < 3000 && req_ready_o !== 1'b1; i++)
         @(negedge clk_sys_i);
      @(posedge clk_sys_i);
      #1 req_valid_i = 1'b0;
      n.due = cyc + (n.err ? 0 : 3 + n_set);
      nq.push_back(n);
      if (i == 3000)
      begin
         n_mismatch++;
         stop_test();
      end
   endtask
   // Take the oldest note whenever an answer appears and compare
   always @(negedge clk_sys_i)
   begin
      if (done_o === 1'b1 && nq.size() > 0)
      begin
         m = nq.pop_front();
         chk("err", err_o, m.err);
         chk("time", cyc, m.due);
         if (!m.err)
         begin
            chk("start", conv_start_o, 1'b1);
            chk("pos", conv_pos_o, m.pos);
            chk("span", conv_span_o, m.span);
            if (m.dif)
               chk("neg", conv_neg_o, m.neg);
            if (m.ch > 7'h0f)
               chk("route", route_ch, m.ch);
         end
      end
      if (reg_rvalid_o === 1'b1)
         chk("rdata", reg_rdata_o, rq.size() ? rq.pop_front() : 32'hx);
   end
   // Main sequence
   initial
   begin
      {rst_n_i, reg_wr_i, reg_rd_i, req_valid_i, req_diff_i} = 5'h00;
      {req_stream_i, req_first_i, reg_addr_i, reg_wdata_i} = 50'h0;
      req_chan_i = 7'h00;
      expand_mask_i = 14'h0000;
      repeat (8) @(posedge clk_sys_i);
      #1 rst_n_i = 1'b1;
      wait_free();
      reg_read(16'h0fa8, 32'h0);
      reg_read(16'h9ca0, `ECMC_SPAN_RST);
      reg_read(16'hab7c, `ECMC_SPAN_RST);
      reg_read(16'hab80, 32'h0);
      reg_read(16'h0001, 32'h0);
      reg_write(16'h9ca0, 32'h3f800000);
      reg_read(16'h9ca0, 32'h3f800000);
      reg_read(16'hab7c, `ECMC_FLOAT_DISAGREE);
      reg_write(16'hab7c, 32'h40000000);
      reg_read(16'h9d3e, 32'h40000000);
      reg_read(16'hab7c, 32'h40000000);
      reg_write(16'hab80, 32'h476a6000);
      reg_read(16'hab80, `ECMC_SETTLE_MAX);
      reg_read(16'ha470, `ECMC_SETTLE_MAX);
      reg_write(16'hab80, 32'h0);
      // Every extended channel once, single-ended
      for (k = 16; k < 128; k++)
         req(7'(k), 1'b0, 1'b0, 1'b0, 0, 32'h40000000);
      // Pairs, refused pairings and one unused built-in number
      req(7'h10, 1'b1, 1'b0, 1'b0, 0, 32'h40000000);
      req(7'h77, 1'b1, 1'b0, 1'b0, 0, 32'h40000000);
      req(7'h18, 1'b1, 1'b0, 1'b0, 0, 32'h40000000);
      req(7'h00, 1'b1, 1'b0, 1'b0, 0, 32'h40000000);
      req(7'h01, 1'b1, 1'b0, 1'b0, 0, 32'h40000000);
      req(7'h0e, 1'b0, 1'b0, 1'b0, 0, 32'h40000000);
      // Random masks and channels
      for (k = 0; k < 24; k++)
      begin
         lfsr = step(lfsr);
         expand_mask_i = lfsr[13:0];
         req(lfsr[6:0], lfsr[15], 1'b0, 1'b0, 0, 32'h40000000);
      end
      // Stream settling: first channel, automatic, then set time
      req(7'h14, 1'b0, 1'b1, 1'b1, 0, 32'h40000000);
      req(7'h15, 1'b0, 1'b1, 1'b0, 1250, 32'h40000000);
      reg_write(16'h0fa8, 32'h40000000);
      req(7'h16, 1'b0, 1'b1, 1'b0, 250, 32'h40000000);
      reg_write(16'h0fa8, 32'h3f000000);
      req(7'h17, 1'b0, 1'b1, 1'b0, 1250, 32'h40000000);
      // Own span and settle time of one channel
      reg_write(16'h9ca4, 32'h40400000);
      reg_write(16'ha474, 32'h40800000);
      reg_read(16'hab80, `ECMC_FLOAT_DISAGREE);
      req(7'h32, 1'b0, 1'b0, 1'b0, 500, 32'h40400000);
      for (k = 0; k < 900 && nq.size() > 0; k++)
         @(posedge clk_sys_i);
      repeat (4) @(posedge clk_sys_i);
      chk("pending", nq.size() + rq.size(), 32'h0);
      stop_test();
   end
endmodule
